// ==== common/embus_map.svh ====
// register offsets, field positions, reset values and timing counts of the bus block
`ifndef EMBUS_MAP_SVH
`define EMBUS_MAP_SVH
`define OFS_BUS_CTRL 8'h00
`define OFS_HIPORT_DATA 8'h04
`define OFS_HIPORT_DIR 8'h08
`define OFS_GENPORT_DATA 8'h0C
`define OFS_GENPORT_MODE 8'h10
`define OFS_CTRL_PORT_MODE 8'h14
`define OFS_PORT_CONFIG 8'h18
`define OFS_STOP_RECOVERY 8'h1C
`define OFS_WATCHDOG_MODE 8'h20
`define OFS_WATCHDOG_KICK 8'h24
`define OFS_XADDR 8'h28
`define OFS_XWDATA 8'h2C
`define OFS_XCMD 8'h30
`define OFS_XSTATUS 8'h34
`define OFS_RESET_CAUSE 8'h38
`define OFS_START_ADDR 8'h3C
`define BIT_FLOAT 0
`define BIT_EXT_TIMING 1
`define BIT_LO_NIB_ADDR 2
`define BIT_HI_NIB_ADDR 3
`define BIT_EXT_PROG 4
`define BIT_HS_HIPORT 0
`define BIT_HS_GENPORT 1
`define BIT_DM_ENABLE 2
`define BIT_WDT_ENABLE 2
`define BIT_XCMD_WRITE 2
`define VECTOR_BYTES 16'h000C
`define ROM_TOP 16'h1000
`define WDT_BASE_TICKS 8'h07
`define WDT_TICK_US 500
`define CLK_MHZ 20
`define EXT_EXTRA_CYCLES 2'h2
`define POR_DELAY_CYCLES 1000
`endif

// ==== common/embus_pkg.sv ====
// types shared by the external memory bus block
package embus_pkg;
	typedef enum logic [1:0] {B_IDLE, B_AS, B_GAP, B_DS} bus_state_t;
	typedef enum logic [1:0] {K_FETCH, K_CONST, K_DATA} xkind_t;
endpackage : embus_pkg

// ==== rtl/embus_top.sv ====
// external memory bus master, reset sequencer, port handshakes and watchdog
// Contract
// RQ1: data strobe goes low exactly once per external transfer.
// RQ2: memory must drive read data before data strobe rises.
// RQ3: write data is valid on the bus by data strobe's fall.
// RQ4: address strobe pulses once per cycle; address valid at its rise.
// RQ5: software can float both strobes, direction line and address ports.
// RQ6: direction line is low while writing external memory.
// RQ7: high port gives A11-A8 or A15-A8; upper nibble free for I/O.
// RQ8: romless reset sets full high address and extended timing; else input.
// RQ9: high port handshake on two control lines, direction from upper nibble.
// RQ10: general port bits set independently; handshake follows bit 7 direction.
// RQ11: reset on power-on, watchdog, stop recovery, external, low voltage.
// RQ12: power-on and watchdog reset drive reset pin low for delay.
// RQ13: in reset data strobe low, address strobe toggles; start at 000C.
// RQ14: after start, strobes move only during external accesses.
// RQ15: stop recovery keeps the five mode and configuration registers.
// RQ16: lowest 12 program bytes hold six 16-bit vectors.
// RQ17: ROM mode serves 12..4095 internally, 4096 up go external.
// RQ18: ROM protect refuses constant and external loads in external mode.
// RQ19: two-bit watchdog code picks delay; lower supply doubles it.
// RQ20: low rom-disable input runs everything from external memory.
// RQ21: extended timing adds two clock periods to each transfer.
// RQ22: data space select high for constant loads, low for data loads.
// RQ23: direction line high during reads and whenever not writing.
`include "embus_map.svh"
`timescale 1ns/1ps
`default_nettype none
module embus_top
	import embus_pkg::*;
#(
	parameter int POR_CYCLES = `POR_DELAY_CYCLES,
	parameter int TICK_CYCLES = `WDT_TICK_US * `CLK_MHZ,
	parameter bit ROM_PROTECT = 1'b1
) (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	// apb
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// external memory strobes
	output logic ADDRESS_STROBE_N_OUT,
	output logic ADDRESS_STROBE_OE_OUT,
	output logic DATA_STROBE_N_OUT,
	output logic DATA_STROBE_OE_OUT,
	output logic READ_WRITE_N_OUT,
	output logic READ_WRITE_OE_OUT,
	output logic DATA_SPACE_SELECT_N_OUT,
	// high address port and address/data port
	input wire logic [7:0] HIGH_ADDRESS_PORT_LINES_IN,
	output logic [7:0] HIGH_ADDRESS_PORT_LINES_OUT,
	output logic [7:0] HIGH_ADDRESS_PORT_LINES_OE_OUT,
	input wire logic [7:0] ADDR_DATA_LINES_IN,
	output logic [7:0] ADDR_DATA_LINES_OUT,
	output logic ADDR_DATA_LINES_OE_OUT,
	// general port
	input wire logic [7:0] GENERAL_PORT_LINES_IN,
	output logic [7:0] GENERAL_PORT_LINES_OUT,
	output logic [7:0] GENERAL_PORT_LINES_OE_OUT,
	// handshake control lines
	input wire logic CTRL_PORT_LINE2_IN,
	output logic CTRL_PORT_LINE5_OUT,
	input wire logic CTRL_PORT_LINE1_IN,
	output logic CTRL_PORT_LINE6_OUT,
	// reset sources and straps
	input wire logic INTERNAL_ROM_DISABLE_N_IN,
	input wire logic POWER_OK_EVENT_IN,
	input wire logic LOW_VOLTAGE_RECOVERY_IN,
	input wire logic STOP_RECOVERY_EVENT_IN,
	input wire logic STOP_MODE_IN,
	input wire logic LOW_SUPPLY_IN,
	input wire logic RESET_PIN_IN,
	output logic RESET_PIN_OUT,
	output logic RESET_PIN_OE_OUT,
	output logic EXEC_START_OUT
);
	bus_state_t state;
	xkind_t kind;
	logic [15:0] seq_cnt;
	logic drive_pin;
	logic in_reset;
	logic rst_start;
	logic full_clear;
	logic rom_off;
	logic [4:0] cause;
	logic [4:0] next_cause;
	logic wdt_fire;
	logic as_tog;
	logic was_reset;
	logic started;
	logic [7:0] bus_ctrl;
	logic [7:0] hiport_data;
	logic [1:0] hiport_dir;
	logic [7:0] genport_data;
	logic [7:0] genport_mode_reg;
	logic [7:0] ctrl_port_mode_reg;
	logic [7:0] port_config_reg;
	logic [7:0] stop_recovery_config;
	logic [2:0] watchdog_mode_reg;
	logic [15:0] xaddr;
	logic [7:0] xwdata;
	logic [7:0] xrdata;
	logic xwrite;
	logic refused;
	logic busy;
	logic [1:0] ext_cnt;
	logic wr_en;
	logic setup;
	logic cmd_go;
	logic go_internal;
	logic go_refuse;
	logic [15:0] tick_cnt;
	logic [7:0] wdt_cnt;
	logic [7:0] wdt_limit;
	logic [1:0] lo_dir_eff;
	logic [31:0] next_rdata;
	logic next_err;
	logic [1:0] hs_en;
	logic [1:0] hs_out;
	logic [1:0] hs_load;
	logic [1:0] hs_line_in;
	logic [1:0] hs_line_out;
	logic [7:0] hs_pins [2];
	logic [7:0] hs_latch [2];

	assign setup = PSEL_IN && !PENABLE_IN;
	assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign PREADY_OUT = 1'b1;

	// reset sequencing
	assign rst_start = POWER_OK_EVENT_IN || wdt_fire || STOP_RECOVERY_EVENT_IN ||
		LOW_VOLTAGE_RECOVERY_IN || (!RESET_PIN_IN && !drive_pin); // RQ11
	// stop recovery and watchdog out of stop keep the five mode registers
	assign full_clear = !RST_N_IN || POWER_OK_EVENT_IN || LOW_VOLTAGE_RECOVERY_IN ||
		(!RESET_PIN_IN && !drive_pin) || (wdt_fire && !STOP_MODE_IN); // RQ15
	assign in_reset = seq_cnt != 16'h0000;
	assign next_cause = {LOW_VOLTAGE_RECOVERY_IN, !RESET_PIN_IN && !drive_pin,
		STOP_RECOVERY_EVENT_IN, wdt_fire, POWER_OK_EVENT_IN};

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			seq_cnt <= POR_CYCLES[15:0];
			drive_pin <= 1'b1;
		end else if (rst_start) begin
			seq_cnt <= POR_CYCLES[15:0];
			drive_pin <= POWER_OK_EVENT_IN || wdt_fire; // RQ12
		end else if (in_reset) begin
			seq_cnt <= seq_cnt - 16'h0001;
			if (seq_cnt == 16'h0001)
				drive_pin <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN)
			cause <= 5'h01;
		else if (rst_start)
			cause <= next_cause;
	end

	assign RESET_PIN_OUT = 1'b0;
	assign RESET_PIN_OE_OUT = drive_pin; // RQ12

	// address strobe runs at half the clock rate while reset lasts
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || !in_reset)
			as_tog <= 1'b1;
		else
			as_tog <= !as_tog; // RQ13
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			was_reset <= 1'b1;
			started <= 1'b0;
			EXEC_START_OUT <= 1'b0;
		end else begin
			was_reset <= in_reset;
			EXEC_START_OUT <= was_reset && !in_reset; // RQ13
			if (in_reset)
				started <= 1'b0;
			else if (was_reset)
				started <= 1'b1;
		end
	end

	// strap caught on every full clear, never latched asynchronously
	always_ff @(posedge CLOCK_IN) begin
		if (full_clear)
			rom_off <= !INTERNAL_ROM_DISABLE_N_IN; // RQ20
	end

	// registers kept across stop recovery
	always_ff @(posedge CLOCK_IN) begin
		if (full_clear) begin
			genport_mode_reg <= 8'h00;
			ctrl_port_mode_reg <= 8'h00;
			port_config_reg <= 8'h00;
			stop_recovery_config <= 8'h00;
			watchdog_mode_reg <= 3'h0;
		end else if (wr_en) begin
			if (PADDR_IN == `OFS_GENPORT_MODE)
				genport_mode_reg <= PWDATA_IN[7:0]; // RQ10
			else if (PADDR_IN == `OFS_CTRL_PORT_MODE)
				ctrl_port_mode_reg <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_PORT_CONFIG)
				port_config_reg <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_STOP_RECOVERY)
				stop_recovery_config <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_WATCHDOG_MODE)
				watchdog_mode_reg <= PWDATA_IN[2:0];
		end
	end

	// registers cleared by every reset, except that bus_ctrl takes the romless defaults when the strap is low
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || in_reset) begin
			bus_ctrl <= 8'h00;
			hiport_dir <= 2'h0;
			if (!INTERNAL_ROM_DISABLE_N_IN) begin
				bus_ctrl[`BIT_EXT_TIMING] <= 1'b1; // RQ8
				bus_ctrl[`BIT_LO_NIB_ADDR] <= 1'b1;
				bus_ctrl[`BIT_HI_NIB_ADDR] <= 1'b1;
			end
			hiport_data <= 8'h00;
			genport_data <= 8'h00;
			xaddr <= 16'h0000;
			xwdata <= 8'h00;
		end else if (wr_en) begin
			if (PADDR_IN == `OFS_BUS_CTRL)
				bus_ctrl <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_HIPORT_DIR)
				hiport_dir <= PWDATA_IN[1:0];
			else if (PADDR_IN == `OFS_HIPORT_DATA)
				hiport_data <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_GENPORT_DATA)
				genport_data <= PWDATA_IN[7:0];
			else if (PADDR_IN == `OFS_XADDR)
				xaddr <= PWDATA_IN[15:0];
			else if (PADDR_IN == `OFS_XWDATA)
				xwdata <= PWDATA_IN[7:0];
		end
	end

	// transfer launch: internal ROM window, protection, then the bus
	assign cmd_go = wr_en && PADDR_IN == `OFS_XCMD && !busy && !in_reset;
	assign go_internal = !rom_off && xaddr < `ROM_TOP
		&& xkind_t'(PWDATA_IN[1:0]) == K_FETCH; // RQ17 RQ16
	assign go_refuse = ROM_PROTECT && bus_ctrl[`BIT_EXT_PROG]
		&& xkind_t'(PWDATA_IN[1:0]) != K_FETCH; // RQ18
	assign busy = state != B_IDLE;

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || in_reset) begin
			state <= B_IDLE;
			kind <= K_FETCH;
			xwrite <= 1'b0;
			ext_cnt <= 2'h0;
			xrdata <= 8'h00;
		end else begin
			case (state)
				B_IDLE: begin
					if (cmd_go && !go_internal && !go_refuse) begin
						state <= B_AS;
						kind <= xkind_t'(PWDATA_IN[1:0]);
						xwrite <= PWDATA_IN[`BIT_XCMD_WRITE];
					end
				end
				B_AS: state <= B_GAP;
				B_GAP: begin
					state <= B_DS;
					ext_cnt <= bus_ctrl[`BIT_EXT_TIMING] ? `EXT_EXTRA_CYCLES : 2'h0; // RQ21
				end
				B_DS: begin
					if (ext_cnt != 2'h0) begin
						ext_cnt <= ext_cnt - 2'h1;
					end else begin
						state <= B_IDLE;
						if (!xwrite)
							xrdata <= ADDR_DATA_LINES_IN; // RQ2
					end
				end
				default: state <= B_IDLE;
			endcase
		end
	end

	// refused flag: a new refusal wins over a clear in the same cycle
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || in_reset)
			refused <= 1'b0;
		else if (cmd_go && go_refuse)
			refused <= 1'b1; // RQ18
		else if (wr_en && PADDR_IN == `OFS_XSTATUS && PWDATA_IN[1])
			refused <= 1'b0;
	end

	// strobes and direction line
	assign ADDRESS_STROBE_N_OUT = in_reset ? as_tog : state != B_AS; // RQ4 RQ13 RQ14
	assign DATA_STROBE_N_OUT = in_reset ? 1'b0 : state != B_DS; // RQ1 RQ13 RQ14
	assign READ_WRITE_N_OUT = !(busy && xwrite && !in_reset); // RQ6 RQ23
	assign ADDRESS_STROBE_OE_OUT = !bus_ctrl[`BIT_FLOAT]; // RQ5
	assign DATA_STROBE_OE_OUT = !bus_ctrl[`BIT_FLOAT];
	assign READ_WRITE_OE_OUT = !bus_ctrl[`BIT_FLOAT];
	assign DATA_SPACE_SELECT_N_OUT = !(ctrl_port_mode_reg[`BIT_DM_ENABLE]
		&& busy && kind == K_DATA); // RQ22

	// low byte carries address, then write data ahead of the data strobe
	assign ADDR_DATA_LINES_OUT = (state == B_AS || in_reset) ? xaddr[7:0] : xwdata; // RQ3
	assign ADDR_DATA_LINES_OE_OUT = !bus_ctrl[`BIT_FLOAT] && !in_reset &&
		(state == B_AS || state == B_GAP || (state == B_DS && xwrite)); // RQ3 RQ5

	// high port: each nibble is address or plain I/O
	assign lo_dir_eff = hs_en[0] ? {2{hiport_dir[1]}} : hiport_dir; // RQ9
	always_comb begin
		HIGH_ADDRESS_PORT_LINES_OUT = hiport_data;
		HIGH_ADDRESS_PORT_LINES_OE_OUT = {{4{lo_dir_eff[1]}}, {4{lo_dir_eff[0]}}};
		if (bus_ctrl[`BIT_LO_NIB_ADDR]) begin
			HIGH_ADDRESS_PORT_LINES_OUT[3:0] = xaddr[11:8]; // RQ7
			HIGH_ADDRESS_PORT_LINES_OE_OUT[3:0] = {4{!bus_ctrl[`BIT_FLOAT]}}; // RQ5
		end
		if (bus_ctrl[`BIT_HI_NIB_ADDR]) begin
			HIGH_ADDRESS_PORT_LINES_OUT[7:4] = xaddr[15:12]; // RQ7
			HIGH_ADDRESS_PORT_LINES_OE_OUT[7:4] = {4{!bus_ctrl[`BIT_FLOAT]}};
		end
	end

	assign GENERAL_PORT_LINES_OUT = genport_data;
	assign GENERAL_PORT_LINES_OE_OUT = genport_mode_reg; // RQ10

	// handshake channels: 0 on the high port, 1 on the general port
	assign hs_en = {ctrl_port_mode_reg[`BIT_HS_GENPORT], ctrl_port_mode_reg[`BIT_HS_HIPORT]};
	assign hs_out = {genport_mode_reg[7], hiport_dir[1]}; // RQ9 RQ10
	assign hs_load = {wr_en && PADDR_IN == `OFS_GENPORT_DATA,
		wr_en && PADDR_IN == `OFS_HIPORT_DATA};
	assign hs_line_in = {CTRL_PORT_LINE1_IN, CTRL_PORT_LINE2_IN};
	assign hs_pins[0] = HIGH_ADDRESS_PORT_LINES_IN;
	assign hs_pins[1] = GENERAL_PORT_LINES_IN;
	assign CTRL_PORT_LINE5_OUT = hs_line_out[0];
	assign CTRL_PORT_LINE6_OUT = hs_line_out[1];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_hs
			// output side: line_out is data valid, line_in is ready
			// input side: line_in is data valid, line_out is ready
			always_ff @(posedge CLOCK_IN) begin
				if (!RST_N_IN || in_reset || !hs_en[ch]) begin
					hs_line_out[ch] <= 1'b1;
					hs_latch[ch] <= 8'h00;
				end else if (hs_out[ch]) begin
					if (hs_load[ch])
						hs_line_out[ch] <= 1'b0; // RQ9
					else if (hs_line_in[ch])
						hs_line_out[ch] <= 1'b1;
				end else if (!hs_line_in[ch] && hs_line_out[ch]) begin
					hs_latch[ch] <= hs_pins[ch]; // RQ9
					hs_line_out[ch] <= 1'b0;
				end else if (hs_line_in[ch]) begin
					hs_line_out[ch] <= 1'b1;
				end
			end
		end
	endgenerate

	// watchdog: slow tick enable, then a tick count against the selected limit
	assign wdt_limit = (`WDT_BASE_TICKS << (watchdog_mode_reg[1:0] == 2'h3 ? 3'h4 :
		{1'b0, watchdog_mode_reg[1:0]})) << LOW_SUPPLY_IN; // RQ19
	assign wdt_fire = watchdog_mode_reg[`BIT_WDT_ENABLE] && !in_reset
		&& wdt_cnt >= wdt_limit;

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || in_reset || tick_cnt == TICK_CYCLES[15:0] - 16'h0001)
			tick_cnt <= 16'h0000;
		else
			tick_cnt <= tick_cnt + 16'h0001;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN || in_reset || !watchdog_mode_reg[`BIT_WDT_ENABLE] ||
			(wr_en && PADDR_IN == `OFS_WATCHDOG_KICK))
			wdt_cnt <= 8'h00;
		else if (tick_cnt == TICK_CYCLES[15:0] - 16'h0001 && wdt_cnt != 8'hFF)
			wdt_cnt <= wdt_cnt + 8'h01; // RQ19
	end

	// apb read data is taken in the setup cycle and held through the access
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (PADDR_IN == `OFS_BUS_CTRL)
			next_rdata[7:0] = bus_ctrl;
		else if (PADDR_IN == `OFS_HIPORT_DATA)
			next_rdata[7:0] = (hs_en[0] && !hs_out[0]) ? hs_latch[0] : hs_pins[0];
		else if (PADDR_IN == `OFS_HIPORT_DIR)
			next_rdata[1:0] = hiport_dir;
		else if (PADDR_IN == `OFS_GENPORT_DATA)
			next_rdata[7:0] = (hs_en[1] && !hs_out[1]) ? hs_latch[1] : hs_pins[1];
		else if (PADDR_IN == `OFS_GENPORT_MODE)
			next_rdata[7:0] = genport_mode_reg;
		else if (PADDR_IN == `OFS_CTRL_PORT_MODE)
			next_rdata[7:0] = ctrl_port_mode_reg;
		else if (PADDR_IN == `OFS_PORT_CONFIG)
			next_rdata[7:0] = port_config_reg;
		else if (PADDR_IN == `OFS_STOP_RECOVERY)
			next_rdata[7:0] = stop_recovery_config;
		else if (PADDR_IN == `OFS_WATCHDOG_MODE)
			next_rdata[2:0] = watchdog_mode_reg;
		else if (PADDR_IN == `OFS_XADDR)
			next_rdata[15:0] = xaddr;
		else if (PADDR_IN == `OFS_XWDATA)
			next_rdata[7:0] = xwdata;
		else if (PADDR_IN == `OFS_XSTATUS)
			next_rdata[15:0] = {xrdata, 5'h00, rom_off, refused, busy};
		else if (PADDR_IN == `OFS_RESET_CAUSE)
			next_rdata[4:0] = cause;
		else if (PADDR_IN == `OFS_START_ADDR)
			next_rdata[16:0] = {started, `VECTOR_BYTES}; // RQ13
		else if (PADDR_IN != `OFS_WATCHDOG_KICK && PADDR_IN != `OFS_XCMD)
			next_err = 1'b1;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
			PSLVERR_OUT <= 1'b0;
		end else if (setup) begin
			PRDATA_OUT <= next_rdata;
			PSLVERR_OUT <= next_err;
		end
	end

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN || in_reset);

	a_as_before_ds: assert property ($fell(ADDRESS_STROBE_N_OUT) |=> // RQ4
		ADDRESS_STROBE_N_OUT && DATA_STROBE_N_OUT ##1 !DATA_STROBE_N_OUT)
		else $error("data strobe did not follow address strobe");
	a_ds_once: assert property ($rose(DATA_STROBE_N_OUT) |=> // RQ1
		DATA_STROBE_N_OUT && state == B_IDLE)
		else $error("second data strobe in one transfer");
	a_write_data_valid: assert property ($fell(DATA_STROBE_N_OUT) && xwrite |-> // RQ3
		$past(ADDR_DATA_LINES_OE_OUT) && ADDR_DATA_LINES_OUT == xwdata)
		else $error("write data not valid at data strobe fall");
	a_float_all: assert property (bus_ctrl[`BIT_FLOAT] |-> // RQ5
		!ADDRESS_STROBE_OE_OUT && !DATA_STROBE_OE_OUT && !READ_WRITE_OE_OUT
		&& !ADDR_DATA_LINES_OE_OUT)
		else $error("bus not floated");
	a_rw_write: assert property ($rose(busy) && xwrite |-> // RQ6
		!READ_WRITE_N_OUT [*3])
		else $error("direction line high during write");
	a_rw_read_high: assert property (!xwrite || !busy |-> READ_WRITE_N_OUT) // RQ23
		else $error("direction line low outside a write");
	a_ext_length: assert property ($fell(DATA_STROBE_N_OUT) && bus_ctrl[`BIT_EXT_TIMING] |-> // RQ21
		!DATA_STROBE_N_OUT [*3] ##1 DATA_STROBE_N_OUT)
		else $error("extended strobe length wrong");
	a_idle_quiet: assert property (state == B_IDLE && $past(state) == B_IDLE |-> // RQ14
		ADDRESS_STROBE_N_OUT && DATA_STROBE_N_OUT)
		else $error("strobe moved without an access");
	a_rom_internal: assert property (cmd_go && go_internal |=> state == B_IDLE) // RQ17
		else $error("internal fetch went out on the bus");
	a_reset_strobes: assert property (disable iff (!RST_N_IN) // RQ13
		in_reset && $past(in_reset) && $past(RST_N_IN) |-> !DATA_STROBE_N_OUT
		&& ADDRESS_STROBE_N_OUT != $past(ADDRESS_STROBE_N_OUT))
		else $error("reset strobe pattern wrong");
	a_pin_drive: assert property (disable iff (!RST_N_IN) // RQ12
		$rose(in_reset) && $past(POWER_OK_EVENT_IN) |-> RESET_PIN_OE_OUT [*8])
		else $error("reset pin not driven after power-on");
endmodule : embus_top
`default_nettype wire

// ==== bench/ext_memory_model.sv ====
// behavioural external memory on the far side of the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model (
	// clock and strobes
	input wire logic clk_in,
	input wire logic as_n_in,
	input wire logic ds_n_in,
	input wire logic rw_n_in,
	input wire logic dm_n_in,
	// address and data lines as the device drives them
	input wire logic [7:0] hi_in,
	input wire logic [7:0] da_in,
	input wire logic oe_in,
	output logic [7:0] bus_out,
	// observations for the bench
	output logic [15:0] addr_out,
	output logic [7:0] wdata_out,
	output logic rw_n_out,
	output logic dm_n_out,
	output int as_count_out,
	output int ds_count_out,
	output int ds_width_out
);
	logic prev_as = 1'b1;
	logic prev_ds = 1'b1;
	logic [7:0] last = 8'h00;
	// contents are a fixed function of the address so the bench can predict reads;
	// a released line shows the inverse of its last level, never a held value
	assign bus_out = oe_in ? da_in : (!ds_n_in && rw_n_in) ? (addr_out[7:0] ^ 8'h5A) : ~last;
	always @(posedge clk_in) begin
		prev_as <= as_n_in;
		prev_ds <= ds_n_in;
		last <= bus_out;
		if (!as_n_in)
			addr_out <= {hi_in, da_in};
		if (prev_as && !as_n_in)
			as_count_out <= as_count_out + 1;
		if (prev_ds && !ds_n_in) begin
			ds_count_out <= ds_count_out + 1;
			ds_width_out <= 1;
			rw_n_out <= rw_n_in;
			dm_n_out <= dm_n_in;
			if (!rw_n_in)
				wdata_out <= da_in;
		end else if (!ds_n_in)
			ds_width_out <= ds_width_out + 1;
	end
endmodule : ext_memory_model
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the external memory bus block
`timescale 1ns/1ps
`default_nettype none
`include "embus_map.svh"
module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic rom_n = 1'b1;
	logic [3:0] ev = 4'h0;
	logic hs_rdy = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, m_rw, m_dm, hs_dav;
	logic as_n, as_oe, ds_n, ds_oe, rw_n, rw_oe, dm_n, lo_oe, rpin_oe, start;
	logic [7:0] hi_out, hi_oe, hi_in, lo_out, lo_in, gp_out, gp_oe, gp_in, m_wdata;
	logic [15:0] m_addr;
	int as_cnt, ds_cnt, ds_w, k, a0, d0;
	int fails = 0;
	int tests_run = 0;
	// undriven port bits float to a fixed pattern rather than echoing the device
	assign hi_in = (hi_out & hi_oe) | (8'hC3 & ~hi_oe);
	assign gp_in = (gp_out & gp_oe) | (8'h3C & ~gp_oe);
	initial forever #25 clk = ~clk;
	embus_top #(.POR_CYCLES(8), .TICK_CYCLES(4), .ROM_PROTECT(1'b1)) i_embus_top (
		.CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ADDRESS_STROBE_N_OUT(as_n),
		.ADDRESS_STROBE_OE_OUT(as_oe), .DATA_STROBE_N_OUT(ds_n), .DATA_STROBE_OE_OUT(ds_oe),
		.READ_WRITE_N_OUT(rw_n), .READ_WRITE_OE_OUT(rw_oe), .DATA_SPACE_SELECT_N_OUT(dm_n),
		.HIGH_ADDRESS_PORT_LINES_IN(hi_in), .HIGH_ADDRESS_PORT_LINES_OUT(hi_out),
		.HIGH_ADDRESS_PORT_LINES_OE_OUT(hi_oe), .ADDR_DATA_LINES_IN(lo_in),
		.ADDR_DATA_LINES_OUT(lo_out), .ADDR_DATA_LINES_OE_OUT(lo_oe),
		.GENERAL_PORT_LINES_IN(gp_in), .GENERAL_PORT_LINES_OUT(gp_out),
		.GENERAL_PORT_LINES_OE_OUT(gp_oe), .CTRL_PORT_LINE2_IN(hs_rdy),
		.CTRL_PORT_LINE5_OUT(hs_dav),
		.CTRL_PORT_LINE1_IN(1'b1), .CTRL_PORT_LINE6_OUT(), .INTERNAL_ROM_DISABLE_N_IN(rom_n),
		.POWER_OK_EVENT_IN(ev[3]), .LOW_VOLTAGE_RECOVERY_IN(ev[1]),
		.STOP_RECOVERY_EVENT_IN(ev[0]), .STOP_MODE_IN(1'b0), .LOW_SUPPLY_IN(1'b0),
		.RESET_PIN_IN(!(rpin_oe | ev[2])), .RESET_PIN_OUT(), .RESET_PIN_OE_OUT(rpin_oe),
		.EXEC_START_OUT(start)
	);
	ext_memory_model i_ext_memory_model (
		.clk_in(clk), .as_n_in(as_n), .ds_n_in(ds_n), .rw_n_in(rw_n), .dm_n_in(dm_n),
		.hi_in(hi_out), .da_in(lo_out), .oe_in(lo_oe), .bus_out(lo_in), .addr_out(m_addr),
		.wdata_out(m_wdata), .rw_n_out(m_rw), .dm_n_out(m_dm), .as_count_out(as_cnt),
		.ds_count_out(ds_cnt), .ds_width_out(ds_w)
	);
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : check
	// entered right after a rising edge; ends one edge after release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic [2:0] c);
		a0 = as_cnt;
		d0 = ds_cnt;
		apb(1'b1, `OFS_XADDR, {16'h0, a});
		apb(1'b1, `OFS_XWDATA, {24'h0, d});
		apb(1'b1, `OFS_XCMD, {29'h0, c});
		k = 0;
		do begin
			apb(1'b0, `OFS_XSTATUS, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 20);
	endtask : xfer
	task automatic pulse(input int b);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
	endtask : pulse
	task automatic in_reset(input logic oe, input logic [31:0] cause);
		logic a;
		k = 0;
		while (ds_n !== 1'b0 && k < 300) begin
			@(negedge clk);
			k++;
		end
		repeat (2) @(negedge clk);
		a = as_n;
		@(negedge clk);
		check("addr strobe toggle", as_n, !a);
		check("data strobe in reset", ds_n, 1'b0);
		if (oe)
			check("reset pin drive", rpin_oe, 1'b1);
		d0 = 0;
		while (start !== 1'b1 && d0 < 300) begin
			@(negedge clk);
			d0++;
		end
		check("start pulse", start, 1'b1);
		@(posedge clk);
		apb(1'b0, `OFS_RESET_CAUSE, 32'h0);
		check("reset cause", rd, cause);
	endtask : in_reset
	task automatic print_verdict();
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		in_reset(1'b1, 32'h1);
		apb(1'b0, `OFS_START_ADDR, 32'h0);
		check("start address", rd, 32'h0001000C);
		apb(1'b0, `OFS_BUS_CTRL, 32'h0);
		check("rom mode bus ctrl", rd, 32'h0);
		check("rom mode high port", hi_oe, 8'h00);
		apb(1'b0, 8'hFC, 32'h0);
		check("unmapped error", err, 1'b1);
		apb(1'b1, `OFS_GENPORT_MODE, 32'h5A);
		check("general port dir", gp_oe, 8'h5A);
		apb(1'b1, `OFS_HIPORT_DIR, 32'h2);
		apb(1'b1, `OFS_CTRL_PORT_MODE, 32'h5);
		check("handshake nibble dir", hi_oe, 8'hFF);
		apb(1'b1, `OFS_HIPORT_DATA, 32'h5A);
		check("handshake data valid", hs_dav, 1'b0);
		hs_rdy <= 1'b1;
		repeat (2) @(posedge clk);
		check("handshake ready", hs_dav, 1'b1);
		apb(1'b1, `OFS_BUS_CTRL, 32'hC);
		xfer(16'h1234, 8'hA5, 3'h6);
		check("write addr", m_addr, 16'h1234);
		check("write data", m_wdata, 8'hA5);
		check("write dir", m_rw, 1'b0);
		check("data space write", m_dm, 1'b0);
		check("addr strobes", as_cnt - a0, 1);
		check("data strobes", ds_cnt - d0, 1);
		check("idle dir", rw_n, 1'b1);
		xfer(16'h2345, 8'h00, 3'h1);
		check("read data", rd[15:8], 8'h45 ^ 8'h5A);
		check("read dir", m_rw, 1'b1);
		check("data space const", m_dm, 1'b1);
		check("read strobes", ds_cnt - d0, 1);
		xfer(16'h0FFF, 8'h00, 3'h0);
		check("rom fetch", ds_cnt - d0, 0);
		xfer(16'h1000, 8'h00, 3'h0);
		check("ext fetch", ds_cnt - d0, 1);
		apb(1'b1, `OFS_BUS_CTRL, 32'hE);
		xfer(16'h4321, 8'h00, 3'h2);
		check("extended width", ds_w, 3);
		check("extended read", rd[15:8], 8'h21 ^ 8'h5A);
		apb(1'b1, `OFS_BUS_CTRL, 32'h1C);
		xfer(16'h5000, 8'h00, 3'h1);
		check("protect flag", rd[1], 1'b1);
		check("protect strobes", ds_cnt - d0, 0);
		apb(1'b1, `OFS_BUS_CTRL, 32'hD);
		check("float", {as_oe, ds_oe, rw_oe, lo_oe, hi_oe}, 12'h0);
		pulse(0);
		in_reset(1'b0, 32'h4);
		apb(1'b0, `OFS_GENPORT_MODE, 32'h0);
		check("kept mode", rd, 32'h5A);
		apb(1'b0, `OFS_XADDR, 32'h0);
		check("cleared addr", rd, 32'h0);
		pulse(1);
		in_reset(1'b0, 32'h10);
		apb(1'b0, `OFS_GENPORT_MODE, 32'h0);
		check("low voltage clears", rd, 32'h0);
		pulse(3);
		in_reset(1'b1, 32'h1);
		pulse(2);
		in_reset(1'b0, 32'h8);
		apb(1'b1, `OFS_WATCHDOG_MODE, 32'h4);
		in_reset(1'b1, 32'h2);
		check("watchdog delay", k >= 20 && k <= 40, 1'b1);
		rom_n <= 1'b0;
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		in_reset(1'b1, 32'h1);
		apb(1'b0, `OFS_BUS_CTRL, 32'h0);
		check("romless bus ctrl", rd, 32'hE);
		check("romless high port", hi_oe, 8'hFF);
		apb(1'b0, `OFS_XSTATUS, 32'h0);
		check("romless flag", rd[2], 1'b1);
		xfer(16'h0100, 8'h00, 3'h0);
		check("romless fetch", ds_cnt - d0, 1);
		print_verdict();
	end
	// the sequence needs a few hundred cycles; this limit of 30000 cycles is far beyond it
	initial begin
		#(30000 * 50);
		fails++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
